// *** inc/sbcm_pkg.sv ***
// shared constants and types of the operating-mode sequencer
package sbcm_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  // reset delay time, plain default, nanoseconds
  localparam int RST_DELAY_NS    = 10000;
  // least time, rounded up to whole cycles
  localparam int RST_DELAY_CYC   = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W           = 11;
  // long open window of the watchdog, milliseconds
  localparam int LONG_WINDOW_MS  = 200;
  localparam int LONG_WINDOW_CYC = (LONG_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WIN_W           = 32;

  // ---------------------------------------------------------------
  // mode field codes, counter limits and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_STOP    = 2'h1;
  localparam logic [1:0] MODE_SLEEP   = 2'h2;
  localparam logic [1:0] MODE_RSV     = 2'h3;
  localparam logic [1:0] CNT_MAX      = 2'h3;
  localparam logic [1:0] FAILS_FO_LATE = 2'h2;
  localparam logic       RST_OUT_N_INIT = 1'h0;
  localparam logic       CORE_ON_INIT   = 1'h1;

  // ---------------------------------------------------------------
  // operating modes, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_INIT     = 6'h01,
    ST_NORMAL   = 6'h02,
    ST_STOP     = 6'h04,
    ST_SLEEP    = 6'h08,
    ST_RESTART  = 6'h10,
    ST_FAILSAFE = 6'h20
  } sbcm_state_e;

  // ---------------------------------------------------------------
  // whole state of the sequencer
  // ---------------------------------------------------------------
  typedef struct packed {
    sbcm_state_e        st;
    logic [1:0]         mode;
    logic               rst_n;
    logic               pd;
    logic               fo;
    logic               core;
    logic               cfg_ok;
    logic               cfg1;
    logic               failure_count_select_bit;
    logic               dev;
    logic [DLY_W-1:0]   dly;
    logic [WIN_W-1:0]   win;
    logic               win_on;
    logic [1:0]         fails;
    logic [1:0]         wd_rsts;
    logic               wd_flag;
  } sbcm_state_s;

endpackage

// *** logic/sbcm_mode_latch.sv ***
// operating-mode state machine with power-up configuration latch
`timescale 1ns/1ps

module sbcm_mode_latch #(
  parameter int LONG_WINDOW_CYC = sbcm_pkg::LONG_WINDOW_CYC
) (
  // clock, power-on reset, clock enable
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       CE,
  // command side
  input  wire logic       SPI_CMD_STB,
  input  wire logic       SPI_MODE_WR,
  input  wire logic [1:0] SPI_MODE,
  input  wire logic       FAILURE_COUNT_SELECT_BIT,
  input  wire logic       IO_OVERVOLTAGE_RESET_ENABLE,
  input  wire logic       MAX_THREE_RESETS,
  input  wire logic       POWER_ON_FLAG,
  // watchdog events
  input  wire logic       WD_TRIGGER,
  input  wire logic       WD_FAIL_IN,
  // supervision and pins
  input  wire logic       IO_SUPPLY_OK,
  input  wire logic       IO_OVERVOLTAGE_FLAG,
  input  wire logic       THERMAL_SHUTDOWN_LEVEL_TWO,
  input  wire logic       WAKE_EVENT,
  input  wire logic       TEST_PIN_IN,
  input  wire logic       INTERRUPT_PIN_IN,
  // mode and pin outputs
  output logic      [5:0] OP_MODE,
  output logic      [1:0] MODE_FIELD,
  output logic            RESET_OUT_N,
  output logic            INTERRUPT_PD_EN,
  output logic            FAIL_OUTPUT,
  output logic            CORE_SUPPLY_EN,
  output logic            DEV_MODE,
  output logic            WD_RUNNING,
  output logic            WD_FAIL_FLAG,
  // latched configuration
  output logic            PULLUP_CONFIG_STATE_BIT,
  output logic            FAILURE_COUNT_STATE_BIT
);

  sbcm_pkg::sbcm_state_s q_r;
  sbcm_pkg::sbcm_state_s q_nxt;
  logic                  act_ok;
  logic                  dly_done;
  logic                  win_exp;
  logic                  wd_ev;
  logic                  ov_ev;
  logic [1:0]            fails_inc;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // saturating two-bit increment
  function automatic logic [1:0] sat_inc(input logic [1:0] v);
    sat_inc = (v == sbcm_pkg::CNT_MAX) ? v : v + 2'h1;
  endfunction

  // enter restart: reset asserted, mode field cleared
  function automatic sbcm_pkg::sbcm_state_s go_restart(input sbcm_pkg::sbcm_state_s s);
    sbcm_pkg::sbcm_state_s r;
    r        = s;
    r.st     = sbcm_pkg::ST_RESTART;
    r.mode   = sbcm_pkg::MODE_NORMAL;
    r.rst_n  = 1'b0;
    r.core   = 1'b1;
    r.dly    = '0;
    r.win_on = 1'b0;
    return r;
  endfunction

  // enter fail-safe: core supply off, reset asserted
  function automatic sbcm_pkg::sbcm_state_s go_failsafe(input sbcm_pkg::sbcm_state_s s);
    sbcm_pkg::sbcm_state_s r;
    r        = s;
    r.st     = sbcm_pkg::ST_FAILSAFE;
    r.rst_n  = 1'b0;
    r.core   = 1'b0;
    r.pd     = 1'b0;
    r.dly    = '0;
    r.win_on = 1'b0;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  assign act_ok    = (q_r.st == sbcm_pkg::ST_NORMAL) || (q_r.st == sbcm_pkg::ST_STOP) ||
                     (q_r.st == sbcm_pkg::ST_INIT);
  assign dly_done  = !q_r.rst_n && IO_SUPPLY_OK &&
                     ((q_r.st == sbcm_pkg::ST_INIT) || (q_r.st == sbcm_pkg::ST_RESTART)) &&
                     (q_r.dly == sbcm_pkg::DLY_W'(sbcm_pkg::RST_DELAY_CYC - 1));
  assign win_exp   = q_r.win_on && q_r.rst_n && !WD_TRIGGER &&
                     (q_r.win == sbcm_pkg::WIN_W'(LONG_WINDOW_CYC - 1));
  // watchdog failures are ignored while development mode holds
  assign wd_ev     = !q_r.dev && q_r.rst_n && act_ok &&
                     (win_exp || (WD_FAIL_IN && !q_r.win_on));
  assign ov_ev     = IO_OVERVOLTAGE_RESET_ENABLE && IO_OVERVOLTAGE_FLAG && q_r.rst_n &&
                     ((q_r.st == sbcm_pkg::ST_NORMAL) || (q_r.st == sbcm_pkg::ST_STOP));
  assign fails_inc = sat_inc(q_r.fails);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    // reset delay counting and weak pull-down on the interrupt pin
    q_nxt.pd = !q_r.rst_n && IO_SUPPLY_OK && (!q_r.cfg_ok || POWER_ON_FLAG) &&
               ((q_r.st == sbcm_pkg::ST_INIT) || (q_r.st == sbcm_pkg::ST_RESTART));
    if (!q_r.rst_n && IO_SUPPLY_OK && !dly_done &&
        ((q_r.st == sbcm_pkg::ST_INIT) || (q_r.st == sbcm_pkg::ST_RESTART)))
    begin
      q_nxt.dly = q_r.dly + sbcm_pkg::DLY_W'(1);
    end
    // reset output release, configuration latch, long open window
    if (dly_done)
    begin
      q_nxt.rst_n  = 1'b1;
      q_nxt.pd     = 1'b0;
      q_nxt.dly    = '0;
      q_nxt.win    = '0;
      q_nxt.win_on = (q_r.st == sbcm_pkg::ST_INIT) ? TEST_PIN_IN : !q_r.dev;
      if (!q_r.cfg_ok || POWER_ON_FLAG)
      begin
        q_nxt.cfg_ok = 1'b1;
        q_nxt.cfg1   = INTERRUPT_PIN_IN;
        q_nxt.failure_count_select_bit   = FAILURE_COUNT_SELECT_BIT;
      end
      q_nxt.dev = (q_r.st == sbcm_pkg::ST_INIT) ? !TEST_PIN_IN : q_r.dev;
      q_nxt.st  = (q_r.st == sbcm_pkg::ST_INIT) ? q_r.st : sbcm_pkg::ST_NORMAL;
    end
    // long open window count; a valid trigger closes it and clears the reset count
    if (q_r.win_on && q_r.rst_n && !WD_TRIGGER && !win_exp)
    begin
      q_nxt.win = q_r.win + sbcm_pkg::WIN_W'(1);
    end
    if (WD_TRIGGER && q_r.rst_n)
    begin
      q_nxt.win_on  = 1'h0;
      q_nxt.wd_rsts = 2'h0;
    end

    if (THERMAL_SHUTDOWN_LEVEL_TWO)
    begin
      q_nxt = go_failsafe(q_nxt);
    end
    else if (wd_ev)
    begin
      q_nxt.fails   = fails_inc;
      q_nxt.wd_flag = 1'b1;
      if (q_r.failure_count_select_bit || (fails_inc >= sbcm_pkg::FAILS_FO_LATE))
      begin
        q_nxt.fo = 1'b1;
      end
      if (q_r.cfg1)
      begin
        if (MAX_THREE_RESETS && (q_r.wd_rsts == sbcm_pkg::CNT_MAX))
        begin
          q_nxt.win_on = 1'b0;
        end
        else
        begin
          q_nxt         = go_restart(q_nxt);
          q_nxt.wd_rsts = sat_inc(q_r.wd_rsts);
        end
      end
      else if (!q_r.failure_count_select_bit && (fails_inc == 2'h1))
      begin
        q_nxt = go_restart(q_nxt);
      end
      else
      begin
        q_nxt    = go_failsafe(q_nxt);
        q_nxt.fo = 1'b1;
      end
    end
    else if (ov_ev)
    begin
      q_nxt.fo = 1'b1;
      q_nxt    = q_r.cfg1 ? go_restart(q_nxt) : go_failsafe(q_nxt);
    end
    else
    begin
      case (q_r.st)
        sbcm_pkg::ST_INIT:
        begin
          if (q_r.rst_n && SPI_CMD_STB)
          begin
            q_nxt.st = sbcm_pkg::ST_NORMAL;
          end
        end
        sbcm_pkg::ST_NORMAL:
        begin
          if (!IO_SUPPLY_OK)
          begin
            q_nxt = go_restart(q_nxt);
          end
          else if (SPI_MODE_WR && (SPI_MODE == sbcm_pkg::MODE_STOP))
          begin
            q_nxt.st   = sbcm_pkg::ST_STOP;
            q_nxt.mode = sbcm_pkg::MODE_STOP;
          end
          else if (SPI_MODE_WR && (SPI_MODE == sbcm_pkg::MODE_SLEEP))
          begin
            q_nxt.st     = sbcm_pkg::ST_SLEEP;
            q_nxt.mode   = sbcm_pkg::MODE_SLEEP;
            q_nxt.rst_n  = 1'b0;
            q_nxt.core   = 1'b0;
            q_nxt.win_on = 1'b0;
          end
        end
        sbcm_pkg::ST_STOP:
        begin
          if (!IO_SUPPLY_OK || (SPI_MODE_WR && (SPI_MODE == sbcm_pkg::MODE_SLEEP)))
          begin
            q_nxt = go_restart(q_nxt);
          end
          else if (SPI_MODE_WR && (SPI_MODE == sbcm_pkg::MODE_NORMAL))
          begin
            q_nxt.st   = sbcm_pkg::ST_NORMAL;
            q_nxt.mode = sbcm_pkg::MODE_NORMAL;
          end
        end
        sbcm_pkg::ST_SLEEP, sbcm_pkg::ST_FAILSAFE:
        begin
          if (WAKE_EVENT)
          begin
            q_nxt = go_restart(q_nxt);
          end
        end
        sbcm_pkg::ST_RESTART:
        begin
          q_nxt.mode = sbcm_pkg::MODE_NORMAL;
        end
        default:
        begin
          q_nxt = go_restart(q_nxt);
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register, frozen while CE is low
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      q_r         <= '0;
      q_r.st      <= sbcm_pkg::ST_INIT;
      q_r.mode    <= sbcm_pkg::MODE_NORMAL;
      q_r.rst_n   <= sbcm_pkg::RST_OUT_N_INIT;
      q_r.core    <= sbcm_pkg::CORE_ON_INIT;
    end
    else if (CE)
    begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign OP_MODE                 = q_r.st;
  assign MODE_FIELD              = q_r.mode;
  assign RESET_OUT_N             = q_r.rst_n;
  assign INTERRUPT_PD_EN         = q_r.pd;
  assign FAIL_OUTPUT             = q_r.fo;
  assign CORE_SUPPLY_EN          = q_r.core;
  assign DEV_MODE                = q_r.dev;
  assign WD_RUNNING              = q_r.win_on;
  assign WD_FAIL_FLAG            = q_r.wd_flag;
  assign PULLUP_CONFIG_STATE_BIT = q_r.cfg1;
  assign FAILURE_COUNT_STATE_BIT = q_r.failure_count_select_bit;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  init_cmd_a: assert property (CE && (q_r.st == sbcm_pkg::ST_INIT) && q_r.rst_n && SPI_CMD_STB &&
    !wd_ev && !THERMAL_SHUTDOWN_LEVEL_TWO |=> q_r.st == sbcm_pkg::ST_NORMAL)
    else $error("command in init did not reach normal");
  restart_mode_a: assert property ((q_r.st == sbcm_pkg::ST_RESTART) && CE
    |=> (q_r.st != sbcm_pkg::ST_RESTART) || (q_r.mode == sbcm_pkg::MODE_NORMAL))
    else $error("mode field not cleared in restart");
  restart_exit_a: assert property ((q_r.st == sbcm_pkg::ST_RESTART) ##1 (q_r.st == sbcm_pkg::ST_NORMAL)
    |-> q_r.rst_n && !$past(q_r.rst_n))
    else $error("reset output not released on restart exit");
  pd_window_a: assert property (q_r.pd |-> !q_r.rst_n)
    else $error("pull-down active with reset released");
  cfg_hold_a: assert property (q_r.cfg_ok && !POWER_ON_FLAG |=> $stable(q_r.cfg1) && $stable(q_r.failure_count_select_bit))
    else $error("configuration changed without power-on flag");
  cfg_latch_a: assert property (CE && dly_done && (!q_r.cfg_ok || POWER_ON_FLAG)
    |=> q_r.cfg1 == $past(INTERRUPT_PIN_IN))
    else $error("configuration not sampled at reset release");
  dev_halt_a: assert property (q_r.dev && CE && !dly_done |=> $stable(q_r.fails) && !q_r.win_on)
    else $error("watchdog active in development mode");
  pullup_fail_a: assert property (CE && wd_ev && q_r.cfg1 && !MAX_THREE_RESETS && !THERMAL_SHUTDOWN_LEVEL_TWO
    |=> (q_r.st == sbcm_pkg::ST_RESTART) && q_r.core)
    else $error("pull-up config failure did not restart");
  safe_fail_a: assert property (CE && wd_ev && !q_r.cfg1 && q_r.failure_count_select_bit && !THERMAL_SHUTDOWN_LEVEL_TWO
    |=> (q_r.st == sbcm_pkg::ST_FAILSAFE) && q_r.fo && !q_r.core)
    else $error("config 2 failure did not enter fail-safe");
  late_fo_a: assert property (CE && wd_ev && !q_r.failure_count_select_bit && (q_r.fails == 2'h0) && !q_r.fo &&
    !THERMAL_SHUTDOWN_LEVEL_TWO |=> !q_r.fo ##0 (q_r.fails == 2'h1))
    else $error("fail output set on first failure with select bit clear");

endmodule

// *** verif/sbcm_mcu_model.sv ***
// microcontroller model driving commands, mode writes and triggers
`timescale 1ns/1ps

module sbcm_mcu_model (
  // clock and reset line from the device
  input  wire logic       CLK,
  input  wire logic       RESET_OUT_N,
  // command side towards the device
  output logic            SPI_CMD_STB,
  output logic            SPI_MODE_WR,
  output logic      [1:0] SPI_MODE,
  output logic            WD_TRIGGER
);
  logic auto_cmd = 1'h0;
  int   boot_dly = 3;

  // idle command lines at time zero
  initial
  begin
    {SPI_CMD_STB, SPI_MODE_WR, WD_TRIGGER} = 3'h0;
    SPI_MODE = 2'h3;
  end

  // one command cycle, launched off the falling edge
  task automatic pulse(input logic wr, input logic [1:0] val, input logic trg);
  begin
    @(negedge CLK);
    {SPI_CMD_STB, SPI_MODE_WR, WD_TRIGGER} = {1'h1, wr, trg};
    SPI_MODE = val;
    @(negedge CLK);
    {SPI_CMD_STB, SPI_MODE_WR, WD_TRIGGER} = 3'h0;
    SPI_MODE = ~val; // released value is not kept
  end
  endtask

  // one arbitrary command after reset release, delayed like a slow boot
  always @(posedge RESET_OUT_N)
    if (auto_cmd)
    begin
      repeat (boot_dly) @(negedge CLK);
      pulse(1'h0, 2'h3, 1'h0);
    end
endmodule

// *** verif/sbcm_mode_latch_tb.sv ***
// self-checking bench of the operating-mode sequencer
`timescale 1ns/1ps

module sbcm_mode_latch_tb;
  localparam int WIN = 50;
  localparam int DLY = sbcm_pkg::RST_DELAY_CYC;
  logic       CLK = 1'h0;
  logic       NRST, CE, stb, mwr, trg, sel, ovr_en, max3, por_flag, wd_fail;
  logic       io_ok, ov, tsd, wake, test_n, interrupt_out_n_lvl, p, s;
  logic [1:0] mval, mode_fld;
  logic [5:0] op_mode;
  logic       rst_n, pd_en, fo, core, dev, wd_run, wd_flag, cfg1, failure_count_select_bit;
  int         errors = 0;
  int         n_tests = 0;

  // design and controller model
  sbcm_mode_latch #(.LONG_WINDOW_CYC(WIN)) sbcm_mode_latch_i (
    .CLK(CLK), .NRST(NRST), .CE(CE), .SPI_CMD_STB(stb), .SPI_MODE_WR(mwr), .SPI_MODE(mval),
    .FAILURE_COUNT_SELECT_BIT(sel), .IO_OVERVOLTAGE_RESET_ENABLE(ovr_en), .MAX_THREE_RESETS(max3),
    .POWER_ON_FLAG(por_flag), .WD_TRIGGER(trg), .WD_FAIL_IN(wd_fail), .IO_SUPPLY_OK(io_ok),
    .IO_OVERVOLTAGE_FLAG(ov), .THERMAL_SHUTDOWN_LEVEL_TWO(tsd), .WAKE_EVENT(wake),
    .TEST_PIN_IN(test_n), .INTERRUPT_PIN_IN(interrupt_out_n_lvl), .OP_MODE(op_mode), .MODE_FIELD(mode_fld),
    .RESET_OUT_N(rst_n), .INTERRUPT_PD_EN(pd_en), .FAIL_OUTPUT(fo), .CORE_SUPPLY_EN(core),
    .DEV_MODE(dev), .WD_RUNNING(wd_run), .WD_FAIL_FLAG(wd_flag),
    .PULLUP_CONFIG_STATE_BIT(cfg1), .FAILURE_COUNT_STATE_BIT(failure_count_select_bit));
  sbcm_mcu_model sbcm_mcu_model_i (
    .CLK(CLK), .RESET_OUT_N(rst_n), .SPI_CMD_STB(stb), .SPI_MODE_WR(mwr), .SPI_MODE(mval),
    .WD_TRIGGER(trg));

  // 125 MHz clock
  always #4 CLK = ~CLK;

  // compare and report
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
  begin
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  // counts, verdict, end of run
  task automatic stop_test;
  begin
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // bounded wait for a mode, then compare it
  task automatic wait_mode(input logic [5:0] m, input int lim);
  begin
    for (int i = 0; i < lim && op_mode !== m; i++)
      @(negedge CLK);
    chk("op_mode", m, op_mode);
  end
  endtask

  // bounded wait for reset output release
  task automatic wait_rel;
  begin
    for (int i = 0; i < DLY + 20 && rst_n !== 1'h1; i++)
      @(negedge CLK);
    chk("rst_n", 1'h1, rst_n);
  end
  endtask

  // power-on reset with pin levels, then the configuration latch
  task automatic power_up(input logic tst, input logic pu, input logic fs);
  begin
    NRST = 1'h0;
    {test_n, interrupt_out_n_lvl, sel, por_flag, io_ok} = {tst, pu, fs, 2'h3};
    {ovr_en, max3, wd_fail, ov, tsd, wake} = 6'h00;
    repeat (6) @(negedge CLK);
    chk("op_mode", 6'h01, op_mode);
    NRST = 1'h1;
    repeat (3) @(negedge CLK);
    chk("pd_en", 1'h1, pd_en);
    wait_rel();
    chk("pd_en", 1'h0, pd_en);
    chk("cfg1", pu, cfg1);
    chk("failure_count_select_bit", fs, failure_count_select_bit);
    chk("dev", !tst, dev);
    chk("wd_run", tst, wd_run);
    por_flag = 1'h0;
  end
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge CLK);
    errors++;
    $display("Error watchdog expired");
    stop_test();
  end

  // main sequence
  initial
  begin
    CE = 1'h1;
    // first failure reaction of all four configurations
    for (int k = 0; k < 4; k++)
    begin
      {s, p} = k[1:0];
      power_up(1'h1, p, s);
      sbcm_mcu_model_i.pulse(1'h0, 2'h3, 1'h0);
      chk("op_mode", 6'h02, op_mode);
      interrupt_out_n_lvl = !p;
      wait_mode((p || !s) ? sbcm_pkg::ST_RESTART : sbcm_pkg::ST_FAILSAFE, WIN + 20);
      chk("wd_flag", 1'h1, wd_flag);
      chk("fo", s, fo);
      chk("core", p || !s, core);
      if (p || !s)
      begin
        wait_rel();
        chk("op_mode", 6'h02, op_mode);
        chk("mode_fld", 2'h0, mode_fld);
        chk("cfg1", p, cfg1);
        wait_mode(p ? sbcm_pkg::ST_RESTART : sbcm_pkg::ST_FAILSAFE, WIN + 20);
        chk("fo", 1'h1, fo);
        chk("core", p, core);
      end
    end
    // overvoltage reaction with and without pull-up
    for (int k = 0; k < 2; k++)
    begin
      power_up(1'h1, k[0], 1'h0);
      sbcm_mcu_model_i.pulse(1'h0, 2'h3, 1'h1);
      {ovr_en, ov} = 2'h3;
      wait_mode(k[0] ? sbcm_pkg::ST_RESTART : sbcm_pkg::ST_FAILSAFE, 10);
      chk("fo", 1'h1, fo);
    end
    // mode writes, refused code, sleep, wake, undervoltage, thermal
    power_up(1'h1, 1'h1, 1'h1);
    sbcm_mcu_model_i.pulse(1'h0, 2'h3, 1'h1);
    sbcm_mcu_model_i.pulse(1'h1, 2'h1, 1'h0);
    chk("op_mode", 6'h04, op_mode);
    chk("mode_fld", 2'h1, mode_fld);
    sbcm_mcu_model_i.pulse(1'h1, 2'h3, 1'h0);
    chk("op_mode", 6'h04, op_mode);
    // a write while the clock enable is low must not move the mode
    CE = 1'h0;
    sbcm_mcu_model_i.pulse(1'h1, 2'h0, 1'h0);
    chk("op_mode", 6'h04, op_mode);
    CE = 1'h1;
    sbcm_mcu_model_i.pulse(1'h1, 2'h0, 1'h0);
    sbcm_mcu_model_i.pulse(1'h1, 2'h2, 1'h0);
    chk("op_mode", 6'h08, op_mode);
    chk("core", 1'h0, core);
    chk("rst_n", 1'h0, rst_n);
    wake = 1'h1;
    @(negedge CLK);
    wake = 1'h0;
    wait_mode(sbcm_pkg::ST_NORMAL, DLY + 20);
    io_ok = 1'h0;
    repeat (DLY + 20) @(negedge CLK);
    chk("op_mode", 6'h10, op_mode);
    io_ok = 1'h1;
    wait_rel();
    tsd = 1'h1;
    wait_mode(sbcm_pkg::ST_FAILSAFE, 10);
    chk("core", 1'h0, core);
    // development mode: watchdog halted, modes still reachable
    sbcm_mcu_model_i.auto_cmd = 1'h1;
    power_up(1'h0, 1'h1, 1'h1);
    wait_mode(sbcm_pkg::ST_NORMAL, 20);
    sbcm_mcu_model_i.auto_cmd = 1'h0;
    wd_fail = 1'h1;
    repeat (3 * WIN) @(negedge CLK);
    wd_fail = 1'h0;
    chk("op_mode", 6'h02, op_mode);
    chk("wd_flag", 1'h0, wd_flag);
    sbcm_mcu_model_i.pulse(1'h1, 2'h1, 1'h0);
    chk("op_mode", 6'h04, op_mode);
    // sleep straight from stop goes through restart
    sbcm_mcu_model_i.pulse(1'h1, 2'h2, 1'h0);
    chk("op_mode", 6'h10, op_mode);
    chk("mode_fld", 2'h0, mode_fld);
    // at most three watchdog resets
    power_up(1'h1, 1'h1, 1'h1);
    max3 = 1'h1;
    sbcm_mcu_model_i.pulse(1'h0, 2'h3, 1'h0);
    for (int k = 0; k < 3; k++)
    begin
      wait_mode(sbcm_pkg::ST_RESTART, WIN + 20);
      wait_rel();
    end
    repeat (WIN + 20) @(negedge CLK);
    chk("rst_n", 1'h1, rst_n);
    // uncleared power-on flag relatches at the next reset
    power_up(1'h1, 1'h1, 1'h1);
    por_flag = 1'h1;
    sbcm_mcu_model_i.pulse(1'h0, 2'h3, 1'h0);
    interrupt_out_n_lvl = 1'h0;
    wait_mode(sbcm_pkg::ST_RESTART, WIN + 20);
    repeat (3) @(negedge CLK);
    chk("pd_en", 1'h1, pd_en);
    wait_rel();
    chk("cfg1", 1'h0, cfg1);
    chk("fo", 1'h1, fo);
    stop_test();
  end
endmodule
